// file: design/plm_pkg.sv
// Package for the loop lock and clock output monitor block
package plm_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // Register offsets (word addresses on the control port)
  localparam logic [15:0] OFS_LOOP_CTRL_A = 16'hf000;
  localparam logic [15:0] OFS_LOOP_CTRL_B = 16'hf001;
  localparam logic [15:0] OFS_LOOP_SRC = 16'hf002;
  localparam logic [15:0] OFS_LOOP_ENABLE = 16'hf003;
  localparam logic [15:0] OFS_LOCK_STATUS = 16'hf004;
  localparam logic [15:0] OFS_OUT_CTRL = 16'hf005;
  localparam logic [15:0] OFS_MONITOR_CTRL = 16'hf006;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'hf010;
  localparam logic [15:0] OFS_IRQ_MASK = 16'hf011;
  // Reset values
  localparam logic [15:0] RST_LOCK_STATUS = 16'h0000;
  localparam logic [15:0] RST_OUT_CTRL = 16'h0000;
  localparam logic [15:0] RST_MONITOR_CTRL = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // Field positions
  localparam int BIT_LOCK = 0;
  localparam int BIT_DRIVE_EN = 0;
  localparam int RATE_LO = 1;
  localparam int RATE_HI = 2;
  localparam int BIT_WDOG_EN = 0;
  localparam int BIT_LOOP_EN = 0;
  localparam int BIT_SRC_LOOP = 0;
  // Interrupt status bits
  localparam int IRQ_LOCKED = 0;
  localparam int IRQ_UNLOCKED = 1;
  localparam int IRQ_WDOG = 2;
  localparam int IRQ_W = 3;
  // Timing: settle time and unstable holdoff
  localparam int SETTLE_US = 100;
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int RELOCK_GAP = 16;
  localparam int CNT_W = 16;

  typedef enum {LP_OFF, LP_SETTLE, LP_LOCKED, LP_RESET} plm_loop_e;

  typedef struct packed {
    logic [1:0] rate;
    logic driveEn;
  } plm_outclk_s;
endpackage

// file: design/plm_monitor.sv
// Loop lock status, clock output control and loop watchdog
`timescale 1ns/10ps

// Functional notes
// R01: Lock flag bit 0, read only, resets 0
// R02: Lock needs clock, valid settings, enable, settle
// R03: Host polls lock flag before using clock
// R04: Clock output settings apply on enable rise
// R05: Rate field bits 2:1 select x1..x8
// R06: Base rate is predivider output, 3.072 MHz
// R07: Output rates scale with master clock
// R08: Drive enable bit drives pin else Hi-Z
// R09: Watchdog resets unstable loop automatically
// R10: Relock after watchdog reset, same settings
// R11: Watchdog enable resets to 1
// R12: No lock, no clock while disabled
// R13: Enable rise loads all pending settings
// R14: Lock drops on disable or watchdog reset
module plm_monitor
  import plm_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  // Loop sense inputs, asynchronous
  input wire logic refClockStable,
  input wire logic loopUnstable,
  // Predivider tick (base rate) from the clock tree
  input wire logic baseClock,
  // Loop and clock tree controls
  output logic loopRun,
  output logic loopSourceSel,
  output logic [DATA_W-1:0] loopControlA,
  output logic [DATA_W-1:0] loopControlB,
  // Clock output pin
  output logic output_clock_pin_o,
  output logic output_clock_pin_oe,
  // Interrupt
  output logic irq
);

  logic rstSync1_q, rstSync2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire logic rstIn_n = rstSync2_q;

  // Asynchronous inputs through two flops
  logic [2:0] syncA_q, syncB_q;
  always_ff @(posedge clk_sys or negedge rstIn_n) begin
    if (!rstIn_n) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
    end else begin
      syncA_q <= {baseClock, loopUnstable, refClockStable};
      syncB_q <= syncA_q;
    end
  end
  wire logic stableIn = syncB_q[0];
  wire logic unstableIn = syncB_q[1];
  wire logic baseIn = syncB_q[2];

  // Pending (written) and active register copies
  logic [DATA_W-1:0] ctrlA_q, ctrlA_d, ctrlB_q, ctrlB_d;
  logic srcPend_q, srcPend_d, enable_q, enable_d, wdogEn_q, wdogEn_d;
  plm_outclk_s outPend_q, outPend_d, outAct_q, outAct_d;
  logic [DATA_W-1:0] actA_q, actA_d, actB_q, actB_d;
  logic srcAct_q, srcAct_d;
  logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
  logic [DATA_W-1:0] rdData_q, rdData_d;
  logic irq_q, irq_d;

  plm_loop_e state_q, state_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic lock_q, lock_d;
  logic [CNT_W-1:0] phase_q, phase_d, half_q, half_d, sub_q, sub_d, step;
  logic baseLast_q, baseLast_d;
  logic pin_q, pin_d, pinOe_q, pinOe_d;

  wire logic wrHit = regWrite;
  // Settings counted valid when source selects the loop path
  wire logic settingsOk = srcAct_q;

  logic [IRQ_W-1:0] irqEvent;

  always_comb begin
    ctrlA_d = ctrlA_q;
    ctrlB_d = ctrlB_q;
    srcPend_d = srcPend_q;
    enable_d = enable_q;
    wdogEn_d = wdogEn_q;
    outPend_d = outPend_q;
    irqMask_d = irqMask_q;
    if (wrHit) begin
      case (regAddr)
        OFS_LOOP_CTRL_A: ctrlA_d = regWrData;
        OFS_LOOP_CTRL_B: ctrlB_d = regWrData;
        OFS_LOOP_SRC: srcPend_d = regWrData[BIT_SRC_LOOP];
        OFS_LOOP_ENABLE: enable_d = regWrData[BIT_LOOP_EN];
        OFS_OUT_CTRL: begin
          outPend_d.rate = regWrData[RATE_HI:RATE_LO]; // [R05]
          outPend_d.driveEn = regWrData[BIT_DRIVE_EN];
        end
        OFS_MONITOR_CTRL: wdogEn_d = regWrData[BIT_WDOG_EN]; // [R11]
        OFS_IRQ_MASK: irqMask_d = regWrData[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Pending values become active only on enable rise
    actA_d = (enable_d && !enable_q) ? ctrlA_d : actA_q; // [R13]
    actB_d = (enable_d && !enable_q) ? ctrlB_d : actB_q; // [R13]
    srcAct_d = (enable_d && !enable_q) ? srcPend_d : srcAct_q; // [R13]
    outAct_d = (enable_d && !enable_q) ? outPend_d : outAct_q; // [R04] [R13]
  end

  // Loop state: settle, lock, watchdog reset and relock
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    irqEvent = '0;
    if (!enable_q) begin
      state_d = LP_OFF; // [R12]
      count_d = '0;
    end else begin
      case (state_q)
        LP_OFF: begin
          state_d = LP_SETTLE;
          count_d = '0;
        end
        LP_SETTLE: begin
          if (!stableIn || !settingsOk) begin
            count_d = '0; // [R02]
          end else if (count_q >= CNT_W'(SETTLE_CYCLES - 1)) begin
            state_d = LP_LOCKED; // [R02]
            irqEvent[IRQ_LOCKED] = 1'b1;
          end else begin
            count_d = count_q + 1'b1;
          end
          if (wdogEn_q && unstableIn) begin
            state_d = LP_RESET; // [R09]
            count_d = '0;
            irqEvent[IRQ_WDOG] = 1'b1;
          end
        end
        LP_LOCKED: begin
          if (wdogEn_q && unstableIn) begin
            state_d = LP_RESET; // [R09]
            count_d = '0;
            irqEvent[IRQ_WDOG] = 1'b1;
            irqEvent[IRQ_UNLOCKED] = 1'b1;
          end else if (!stableIn) begin
            state_d = LP_SETTLE;
            count_d = '0;
            irqEvent[IRQ_UNLOCKED] = 1'b1;
          end
        end
        LP_RESET: begin
          // Hold reset briefly, then relock using active settings
          if (count_q >= CNT_W'(RELOCK_GAP - 1)) begin
            state_d = LP_SETTLE; // [R10]
            count_d = '0;
          end else begin
            count_d = count_q + 1'b1;
          end
        end
        default: state_d = LP_OFF;
      endcase
    end
    if (enable_q && !enable_d && state_q == LP_LOCKED) begin
      irqEvent[IRQ_UNLOCKED] = 1'b1;
    end
    lock_d = (state_d == LP_LOCKED); // [R01] [R14]
  end

  // Clock output: base half period measured in clocks, split by rate
  // Limitation: multiples are exact only when the rate divides the half
  // period; each base edge realigns the fast phase to avoid drift.
  always_comb begin
    baseLast_d = baseIn;
    phase_d = phase_q + 1'b1;
    half_d = half_q;
    sub_d = sub_q + 1'b1;
    step = half_q >> outAct_q.rate; // [R05] [R07]
    pin_d = pin_q;
    pinOe_d = outAct_q.driveEn; // [R08]
    if (baseIn != baseLast_q) begin
      half_d = phase_q + 1'b1;
      phase_d = '0;
      sub_d = '0;
      pin_d = 1'b1;
    end else if (sub_q + 1'b1 >= step) begin
      sub_d = '0;
      pin_d = ~pin_q;
    end
    if (outAct_q.rate == 2'b00) begin
      pin_d = baseIn; // [R06]
    end
    if (!(state_q == LP_LOCKED) || !outAct_q.driveEn) begin
      pin_d = 1'b0; // [R12]
    end
  end

  // Interrupt status, write one to clear, set wins
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrHit && regAddr == OFS_IRQ_STATUS) begin
      irqStat_d = irqStat_q & ~regWrData[IRQ_W-1:0];
    end
    irqStat_d = irqStat_d | irqEvent;
    irq_d = |(irqStat_d & irqMask_d);
  end

  // Read path, data valid the cycle after the strobe
  always_comb begin
    rdData_d = '0;
    if (regRead) begin
      case (regAddr)
        OFS_LOOP_CTRL_A: rdData_d = ctrlA_q;
        OFS_LOOP_CTRL_B: rdData_d = ctrlB_q;
        OFS_LOOP_SRC: rdData_d[BIT_SRC_LOOP] = srcPend_q;
        OFS_LOOP_ENABLE: rdData_d[BIT_LOOP_EN] = enable_q;
        OFS_LOCK_STATUS: rdData_d[BIT_LOCK] = lock_q; // [R01] [R03]
        OFS_OUT_CTRL: begin
          rdData_d[RATE_HI:RATE_LO] = outPend_q.rate;
          rdData_d[BIT_DRIVE_EN] = outPend_q.driveEn;
        end
        OFS_MONITOR_CTRL: rdData_d[BIT_WDOG_EN] = wdogEn_q;
        OFS_IRQ_STATUS: rdData_d[IRQ_W-1:0] = irqStat_q;
        OFS_IRQ_MASK: rdData_d[IRQ_W-1:0] = irqMask_q;
        default: rdData_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstIn_n) begin
    if (!rstIn_n) begin
      ctrlA_q <= RST_ZERO;
      ctrlB_q <= RST_ZERO;
      actA_q <= RST_ZERO;
      actB_q <= RST_ZERO;
      srcPend_q <= 1'b0;
      srcAct_q <= 1'b0;
      enable_q <= 1'b0;
      wdogEn_q <= RST_MONITOR_CTRL[BIT_WDOG_EN]; // [R11]
      outPend_q <= RST_OUT_CTRL[RATE_HI:0];
      outAct_q <= RST_OUT_CTRL[RATE_HI:0];
      irqStat_q <= '0;
      irqMask_q <= '0;
      irq_q <= 1'b0;
      rdData_q <= '0;
      state_q <= LP_OFF;
      count_q <= '0;
      lock_q <= RST_LOCK_STATUS[BIT_LOCK]; // [R01]
      phase_q <= '0;
      half_q <= '0;
      sub_q <= '0;
      baseLast_q <= 1'b0;
      pin_q <= 1'b0;
      pinOe_q <= 1'b0;
    end else begin
      ctrlA_q <= ctrlA_d;
      ctrlB_q <= ctrlB_d;
      actA_q <= actA_d;
      actB_q <= actB_d;
      srcPend_q <= srcPend_d;
      srcAct_q <= srcAct_d;
      enable_q <= enable_d;
      wdogEn_q <= wdogEn_d;
      outPend_q <= outPend_d;
      outAct_q <= outAct_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      irq_q <= irq_d;
      rdData_q <= rdData_d;
      state_q <= state_d;
      count_q <= count_d;
      lock_q <= lock_d;
      phase_q <= phase_d;
      half_q <= half_d;
      sub_q <= sub_d;
      baseLast_q <= baseLast_d;
      pin_q <= pin_d;
      pinOe_q <= pinOe_d;
    end
  end

  // Loop held off while disabled or in watchdog reset
  logic loopRun_q;
  always_ff @(posedge clk_sys or negedge rstIn_n) begin
    if (!rstIn_n) begin
      loopRun_q <= 1'b0;
    end else begin
      loopRun_q <= enable_d && (state_d != LP_RESET); // [R09] [R12]
    end
  end

  assign loopRun = loopRun_q;
  assign loopSourceSel = srcAct_q;
  assign loopControlA = actA_q;
  assign loopControlB = actB_q;
  assign output_clock_pin_o = pin_q;
  assign output_clock_pin_oe = pinOe_q;
  assign irq = irq_q;
  assign regRdData = rdData_q;

endmodule

// file: test/plm_monitor_props.sv
// Port-level assertions for the loop monitor
`timescale 1ns/10ps
module plm_monitor_props
  import plm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regRdData,
  // Loop and pin
  input wire logic loopUnstable,
  input wire logic loopRun,
  input wire logic output_clock_pin_o,
  input wire logic output_clock_pin_oe,
  input wire logic irq
);
  // Shadow of the monitor enable, seen only through bus writes
  logic wdogEn_q;
  logic wdogEn_d;
  always_comb begin
    wdogEn_d = wdogEn_q;
    if (regWrite && regAddr == OFS_MONITOR_CTRL) begin
      wdogEn_d = regWrData[BIT_WDOG_EN];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdogEn_q <= 1'b1;
    end else begin
      wdogEn_q <= wdogEn_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence runOff;
    !loopRun [*4];
  endsequence
  sequence lockRd;
    regRead && regAddr == OFS_LOCK_STATUS;
  endsequence
  wr_hold_a: assert property (
    regWrite && regAddr == OFS_OUT_CTRL |-> ##2 $stable(output_clock_pin_oe))
    else $error("pin enable moved on write");
  rd_idle_a: assert property (
    !regRead |=> regRdData == 16'h0000) else $error("read data not idle");
  rd_rsvd_a: assert property (
    lockRd |=> regRdData[15:1] == 15'h0000) else $error("lock bits set");
  run_off_a: assert property (
    regWrite && regAddr == OFS_LOOP_ENABLE && !regWrData[BIT_LOOP_EN]
    |=> !loopRun) else $error("loop still running");
  lock_off_a: assert property (
    runOff ##0 lockRd |=> !regRdData[BIT_LOCK]) else $error("lock while off");
  wdog_rst_a: assert property (
    loopUnstable [*7] ##0 wdogEn_q |-> !loopRun) else $error("no loop reset");
  irq_mask_a: assert property (
    regWrite && regAddr == OFS_IRQ_MASK && regWrData[IRQ_W-1:0] == 3'h0
    |=> !irq) else $error("masked irq high");
  pin_idle_a: assert property (
    runOff |-> !output_clock_pin_o) else $error("pin toggles while off");
endmodule

// file: test/plm_monitor_bench.sv
// Self-checking bench for the loop monitor
`timescale 1ns/10ps
module plm_monitor_bench;
  import plm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic refClockStable = 1'b0;
  logic loopUnstable = 1'b0;
  logic baseClock = 1'b0;
  logic [15:0] regRdData, loopControlA, loopControlB, rdv;
  logic [15:0] rnd, prevB;
  logic loopRun, loopSourceSel, irq, drv, prev;
  logic output_clock_pin_o, output_clock_pin_oe;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  // Short settle keeps each lock attempt to a few dozen cycles
  plm_monitor #(.SETTLE_CYCLES(20)) plm_monitor_inst (
    .clk_sys, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .refClockStable, .loopUnstable, .baseClock, .loopRun,
    .loopSourceSel, .loopControlA, .loopControlB, .output_clock_pin_o,
    .output_clock_pin_oe, .irq
  );
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the under one thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    baseClock <= cycles[3];
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    #1;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 rdv = regRdData;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    rd(a);
    chk(rdv, exp);
  endtask
  // Polls rather than waiting a fixed time, lock time is not fixed
  task automatic waitLock();
    int n = 0;
    rd(OFS_LOCK_STATUS);
    while (rdv[BIT_LOCK] !== 1'b1 && n < 200) begin
      rd(OFS_LOCK_STATUS);
      n++;
    end
    chk(rdv, 16'h0001);
  endtask
  task automatic glitch();
    @(posedge clk_sys);
    loopUnstable <= 1'b1;
    repeat (8) @(posedge clk_sys);
    loopUnstable <= 1'b0;
  endtask
  // Base tick period is 16 clocks, so a 64-clock window holds four
  function automatic logic [15:0] expEdges(input logic [1:0] rate,
      input logic on);
    return on ? 16'(4 << rate) : 16'h0000;
  endfunction
  // Counts rising pin edges once the fast phase has realigned
  task automatic rateChk(input logic [1:0] rate, input logic on);
    int edges;
    logic last;
    edges = 0;
    tick(10);
    last = output_clock_pin_o;
    repeat (64) begin
      tick(1);
      if (output_clock_pin_o === 1'b1 && last === 1'b0) begin
        edges++;
      end
      last = output_clock_pin_o;
    end
    chk(16'(edges), expEdges(rate, on));
  endtask
  initial begin
    void'($urandom(32'h6beb1813));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(OFS_LOCK_STATUS, RST_LOCK_STATUS);
    rdchk(OFS_OUT_CTRL, RST_OUT_CTRL);
    rdchk(OFS_MONITOR_CTRL, RST_MONITOR_CTRL);
    rdchk(16'hf0ff, RST_ZERO);
    wr(OFS_LOCK_STATUS, 16'hffff);
    rdchk(OFS_LOCK_STATUS, RST_ZERO);
    wr(OFS_LOOP_SRC, 16'h0001);
    wr(OFS_OUT_CTRL, 16'h0007);
    rdchk(OFS_OUT_CTRL, 16'h0007);
    chkBit(output_clock_pin_oe, 1'b0);
    chkBit(loopSourceSel, 1'b0);
    wr(OFS_LOOP_ENABLE, 16'h0001);
    tick(60);
    rdchk(OFS_LOCK_STATUS, 16'h0000);
    @(posedge clk_sys);
    refClockStable <= 1'b1;
    waitLock();
    chkBit(output_clock_pin_oe, 1'b1);
    chkBit(loopSourceSel, 1'b1);
    rateChk(2'b11, 1'b1);
    wr(OFS_IRQ_MASK, 16'h0007);
    tick(2);
    chkBit(irq, 1'b1);
    wr(OFS_IRQ_STATUS, 16'h0007);
    tick(2);
    chkBit(irq, 1'b0);
    glitch();
    tick(1);
    rdchk(OFS_LOCK_STATUS, 16'h0000);
    waitLock();
    chkBit(output_clock_pin_oe, 1'b1);
    chkBit(irq, 1'b1);
    wr(OFS_IRQ_MASK, 16'h0000);
    tick(2);
    chkBit(irq, 1'b0);
    rdchk(OFS_IRQ_STATUS, 16'h0007);
    wr(OFS_MONITOR_CTRL, 16'h0000);
    glitch();
    tick(30);
    rdchk(OFS_LOCK_STATUS, 16'h0001);
    wr(OFS_MONITOR_CTRL, 16'h0001);
    prev = 1'b1;
    prevB = 16'h0000;
    for (int c = 0; c < 4; c++) begin
      drv = 1'($urandom);
      rnd = 16'($urandom);
      wr(OFS_OUT_CTRL, {13'h0000, 2'(c), drv});
      wr(OFS_LOOP_CTRL_A, rnd);
      wr(OFS_LOOP_CTRL_B, ~rnd);
      rdchk(OFS_LOOP_CTRL_A, rnd);
      chkBit(output_clock_pin_oe, prev);
      chk(loopControlB, prevB);
      wr(OFS_LOOP_ENABLE, 16'h0000);
      tick(4);
      chkBit(loopRun, 1'b0);
      rdchk(OFS_LOCK_STATUS, 16'h0000);
      wr(OFS_LOOP_ENABLE, 16'h0001);
      waitLock();
      chkBit(output_clock_pin_oe, drv);
      chk(loopControlA, rnd);
      chk(loopControlB, ~rnd);
      rateChk(2'(c), drv);
      prev = drv;
      prevB = ~rnd;
    end
    final_report();
  end
endmodule
bind plm_monitor plm_monitor_props plm_monitor_props_inst (
  .clk_sys, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData, .loopUnstable, .loopRun, .output_clock_pin_o,
  .output_clock_pin_oe, .irq
);
